// ==== design/operation_mode_sequencer.sv ====
// front-panel mode sequencer: hold timing, frame slot source and display selection
// What this block does
// - reset enters playback; display shows active mode
// - three-second hold enters edit or configuration
// - both keys held enter fixture test
// - holding selecting key again returns to playback
// - transitions accepted from every state
// - channel values 0..255, at most 512 channels
// - playback and test frames carry 256 channels
// - channels 1-160 live, 161-256 zero
// - sixteen fixtures of sixteen channels each
// - 240 scenes as 30 banks of 8
// - six chases of up to 250 steps
// - first line shows current mode name, or the chase label while playback runs a chase
// - playback shows bank/scene, or chase and step
// - edit shows bank/scene, plus overlay entry
// - configuration second line names open menu
// - fixture test leaves second line blank
// - messages override display, then revert
`timescale 1ns/1ps
`include "opmode_defines.svh"

module operation_mode_sequencer
    import opmode_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = `HOLD_CYCLES,
    parameter int unsigned MSG_CYCLES  = `MSG_CYCLES,
    parameter int unsigned CH_FRAME    = `CH_FRAME,
    parameter int unsigned CH_LIVE     = `CH_LIVE
) (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic       edit_key_pin,
    input  wire logic       config_key_pin,
    input  wire panel_s     panel,
    input  wire ch_wr_s     ch_wr,
    input  wire logic       msg_req,
    input  wire logic [7:0] msg_code,
    output mode_e           mode,
    output disp_s           disp,
    output slot_s           slot,
    output logic            slot_valid,
    input  wire logic       slot_ready
);

    function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] top);
        clamp = (v > top) ? top : v;
    endfunction

    // fixture f owns internal channels f*16 .. f*16+15
    function automatic logic [7:0] chan_index(input logic [3:0] fix, input logic [3:0] fch);
        chan_index = {fix, fch};
    endfunction

    // reset release and key synchronisers
    logic rst_s1, rst_n;
    logic edit_s1, edit_s2, cfg_s1, cfg_s2;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            edit_s1 <= 1'b0;
            edit_s2 <= 1'b0;
            cfg_s1  <= 1'b0;
            cfg_s2  <= 1'b0;
        end else begin
            edit_s1 <= edit_key_pin;
            edit_s2 <= edit_s1;
            cfg_s1  <= config_key_pin;
            cfg_s2  <= cfg_s1;
        end
    end

    // hold timer
    logic [1:0]  combo_q;
    logic [31:0] hold_cnt;
    logic        fired;

    wire  [1:0]  combo     = {edit_s2, cfg_s2};
    wire         combo_chg = combo != combo_q;
    wire         hold_idle = combo_chg || (combo == 2'b00);
    wire         hold_end  = hold_cnt == 32'(HOLD_CYCLES - 1);
    // one fire per hold: keeping the keys down past three seconds does not toggle again
    wire         hold_fire = !hold_idle && !fired && hold_end;
    wire mode_e  target    = (combo == 2'b10) ? EDIT : (combo == 2'b01) ? CONFIG : TEST;
    wire mode_e  next_mode = !hold_fire ? mode : (mode == target) ? PLAY : target;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            combo_q  <= 2'b00;
            hold_cnt <= 32'h0;
            fired    <= 1'b0;
        end else begin
            combo_q <= combo;
            if (hold_idle) begin
                hold_cnt <= 32'h0;
                fired    <= 1'b0;
            end else begin
                if (!hold_end)
                    hold_cnt <= hold_cnt + 32'h1;
                if (hold_fire)
                    fired <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            mode <= PLAY;
        else
            mode <= next_mode;
    end

    // temporary message
    logic        msg_on;
    logic [31:0] msg_cnt;
    logic [7:0]  msg_val;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            msg_on  <= 1'b0;
            msg_cnt <= 32'h0;
            msg_val <= 8'h00;
        end else if (msg_req) begin
            // a new message restarts the window instead of queueing
            msg_on  <= 1'b1;
            msg_cnt <= 32'h0;
            msg_val <= msg_code;
        end else if (msg_on) begin
            if (msg_cnt == 32'(MSG_CYCLES - 1))
                msg_on <= 1'b0;
            else
                msg_cnt <= msg_cnt + 32'h1;
        end
    end

    // display content
    wire [7:0] bank_v  = clamp(panel.bank, 8'(`BANKS - 1));
    wire [7:0] scene_v = clamp(panel.scene, 8'(`SCENES_PER_BANK - 1));
    wire [7:0] chase_v = clamp(panel.chase_id, 8'(`CHASES - 1));
    wire [7:0] step_v  = clamp(panel.chase_step, 8'(`CHASE_STEPS - 1));
    wire       chase_on = panel.chase_run && (mode == PLAY);
    disp_s     next_disp;

    always_comb begin
        next_disp      = '0;
        next_disp.mode = mode;
        next_disp.l1   = chase_on ? L1_CHASE : L1_MODE;
        next_disp.l2   = L2_BANK_SCENE;
        next_disp.a    = bank_v;
        next_disp.b    = scene_v;
        unique case (mode)
            PLAY: begin
                if (chase_on) begin
                    next_disp.l2 = L2_STEP;
                    next_disp.a  = chase_v;
                    next_disp.b  = step_v;
                end
            end
            EDIT: begin
                if (panel.overlay)
                    next_disp.l2 = L2_OVERLAY;
            end
            CONFIG: begin
                next_disp.l2 = L2_MENU;
                next_disp.a  = 8'(panel.menu);
                next_disp.b  = 8'h00;
            end
            TEST: begin
                next_disp.l2 = L2_BLANK;
                next_disp.a  = 8'h00;
                next_disp.b  = 8'h00;
            end
        endcase
        if (msg_on) begin
            next_disp.l1 = L1_MSG;
            next_disp.l2 = L2_MSG;
            next_disp.a  = msg_val;
            next_disp.b  = 8'h00;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            disp <= '{l1: L1_MODE, l2: L2_BANK_SCENE, mode: PLAY, a: 8'h00, b: 8'h00};
        else
            disp <= next_disp;
    end

    // live channel store and frame slot source
    logic [7:0] live_mem [CH_LIVE];
    logic [8:0] idx;

    wire [7:0] wr_idx  = chan_index(ch_wr.fixture, ch_wr.fch);
    wire       wr_ok   = ch_wr.en && (9'(wr_idx) < 9'(CH_LIVE));
    wire       tx_mode = (mode == PLAY) || (mode == TEST);
    // a frame in flight is finished even if the mode leaves playback mid-frame
    wire       tx_more = tx_mode || (idx != 9'h0);
    wire       load    = !slot_valid || slot_ready;
    wire       idx_end = idx == 9'(CH_FRAME - 1);
    wire [7:0] idx_val = (idx < 9'(CH_LIVE)) ? live_mem[idx[7:0]] : 8'h00;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < int'(CH_LIVE); i++)
                live_mem[i] <= 8'h00;
        end else if (wr_ok) begin
            live_mem[wr_idx] <= ch_wr.value;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            idx        <= 9'h0;
            slot_valid <= 1'b0;
            slot       <= '0;
        end else if (load) begin
            slot_valid <= tx_more;
            if (tx_more) begin
                slot.num  <= idx + 9'h1;
                slot.data <= idx_val;
                slot.last <= idx_end;
                idx       <= idx_end ? 9'h0 : idx + 9'h1;
            end
        end
    end

    // checks
    a_reset_play: assert property (@(posedge mclk) $rose(rst_n) |-> mode == PLAY)
        else $error("mode not playback after reset");

    a_disp_mode: assert property (@(posedge mclk) disable iff (!rst_n)
        (disp.l1 != L1_MSG) |-> disp.mode == $past(mode))
        else $error("display mode differs from active mode");

    a_short_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        (mode != $past(mode)) |-> $past(hold_cnt) == 32'(HOLD_CYCLES - 1))
        else $error("mode changed before full hold");

    a_hold_restart: assert property (@(posedge mclk) disable iff (!rst_n)
        (combo != $past(combo)) |=> hold_cnt == 32'h0)
        else $error("hold timer not restarted");

    a_edit_enter: assert property (@(posedge mclk) disable iff (!rst_n)
        (hold_fire && combo == 2'b10 && mode != EDIT) |=> mode == EDIT)
        else $error("edit hold did not enter edit");

    a_test_enter: assert property (@(posedge mclk) disable iff (!rst_n)
        (hold_fire && combo == 2'b11 && mode != TEST) |=> mode == TEST)
        else $error("both-key hold did not enter test");

    a_return_play: assert property (@(posedge mclk) disable iff (!rst_n)
        (hold_fire && mode != PLAY && target == mode) |=> mode == PLAY)
        else $error("repeat hold did not return to playback");

    a_zero_tail: assert property (@(posedge mclk) disable iff (!rst_n)
        (slot_valid && slot.num > 9'(CH_LIVE)) |-> slot.data == 8'h00)
        else $error("channel above live range not zero");

    a_frame_len: assert property (@(posedge mclk) disable iff (!rst_n)
        slot_valid |-> (slot.last == (slot.num == 9'(CH_FRAME))) && slot.num != 9'h0)
        else $error("frame slot numbering wrong");

    a_test_blank: assert property (@(posedge mclk) disable iff (!rst_n)
        ($past(mode) == TEST && !$past(msg_on)) |-> disp.l2 == L2_BLANK)
        else $error("test mode second line not blank");

    a_msg_revert: assert property (@(posedge mclk) disable iff (!rst_n)
        (msg_on && !msg_req && msg_cnt == 32'(MSG_CYCLES - 1)) |=> ##1 disp.l1 != L1_MSG)
        else $error("message did not revert");

    a_config_enter: assert property (@(posedge mclk) disable iff (!rst_n)
        (hold_fire && combo == 2'b01 && mode != CONFIG) |=> mode == CONFIG)
        else $error("configuration hold did not enter configuration");

    // the mode line checks a_play_lines to a_test_zero skip the first edge after reset, where disp still holds its reset value
    a_play_lines: assert property (@(posedge mclk) disable iff (!rst_n)
        ($past(rst_n) && $past(mode) == PLAY && !$past(msg_on) && !$past(panel.chase_run))
        |-> disp.l1 == L1_MODE && disp.l2 == L2_BANK_SCENE)
        else $error("playback lines wrong");

    a_chase_lines: assert property (@(posedge mclk) disable iff (!rst_n)
        ($past(rst_n) && $past(mode) == PLAY && !$past(msg_on) && $past(panel.chase_run))
        |-> disp.l1 == L1_CHASE && disp.l2 == L2_STEP)
        else $error("chase lines wrong");

    a_edit_lines: assert property (@(posedge mclk) disable iff (!rst_n)
        ($past(rst_n) && $past(mode) == EDIT && !$past(msg_on))
        |-> disp.l1 == L1_MODE
            && disp.l2 == ($past(panel.overlay) ? L2_OVERLAY : L2_BANK_SCENE))
        else $error("edit lines wrong");

    a_menu_line: assert property (@(posedge mclk) disable iff (!rst_n)
        ($past(rst_n) && $past(mode) == CONFIG && !$past(msg_on))
        |-> disp.l2 == L2_MENU && disp.a == 8'($past(panel.menu)) && disp.b == 8'h00)
        else $error("configuration line does not name the menu");

    a_test_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        ($past(rst_n) && $past(mode) == TEST && !$past(msg_on))
        |-> disp.a == 8'h00 && disp.b == 8'h00)
        else $error("test mode second line carries data");

    a_msg_show: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(msg_on) |-> disp.l1 == L1_MSG && disp.l2 == L2_MSG && disp.a == $past(msg_val))
        else $error("message not shown");

    a_bank_range: assert property (@(posedge mclk) disable iff (!rst_n)
        (disp.l2 == L2_BANK_SCENE || disp.l2 == L2_OVERLAY)
        |-> disp.a < 8'(`BANKS) && disp.b < 8'(`SCENES_PER_BANK))
        else $error("bank or scene out of range");

    a_step_range: assert property (@(posedge mclk) disable iff (!rst_n)
        disp.l2 == L2_STEP |-> disp.a < 8'(`CHASES) && disp.b < 8'(`CHASE_STEPS))
        else $error("chase or step out of range");

    a_store_write: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_ok |=> live_mem[$past(wr_idx)] == $past(ch_wr.value))
        else $error("channel write not stored");

    a_slot_range: assert property (@(posedge mclk) disable iff (!rst_n)
        slot_valid |-> slot.num >= 9'h001 && slot.num <= 9'(CH_FRAME))
        else $error("slot number outside the frame");

    // a refused slot must not move, or the sink would see a skipped channel
    a_slot_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        (slot_valid && !slot_ready) |=> slot_valid && $stable(slot))
        else $error("refused slot changed");

    a_frame_start: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(slot_valid) |-> slot.num == 9'h001)
        else $error("stream did not start at channel one");

    a_frame_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
        (slot_valid && slot_ready && slot.last) |=> !slot_valid || slot.num == 9'h001)
        else $error("frame did not wrap to channel one");

    a_idle_stop: assert property (@(posedge mclk) disable iff (!rst_n)
        (mode != PLAY && mode != TEST && idx == 9'h0 && slot_valid && slot_ready)
        |=> !slot_valid)
        else $error("new frame started outside transmitting modes");

endmodule // operation_mode_sequencer

// ==== design/opmode_defines.svh ====
// timing counts, channel map limits and storage sizes of the mode sequencer
`ifndef OPMODE_DEFINES_SVH
`define OPMODE_DEFINES_SVH
`define CLK_MHZ          100
`define HOLD_TIME_MS     3000
`define MSG_TIME_MS      3000
`define HOLD_CYCLES      (`HOLD_TIME_MS * 1000 * `CLK_MHZ)
`define MSG_CYCLES       (`MSG_TIME_MS * 1000 * `CLK_MHZ)
`define UNIVERSE_MAX     512
`define CH_FRAME         256
`define CH_LIVE          160
`define CH_MAX_VALUE     255
`define FIXTURES         16
`define CH_PER_FIX       16
`define BANKS            30
`define SCENES_PER_BANK  8
`define CHASES           6
`define CHASE_STEPS      250
`endif

// ==== design/opmode_pkg.sv ====
// types shared by the operation mode sequencer and its bench
package opmode_pkg;
    typedef enum logic [1:0] {PLAY, EDIT, CONFIG, TEST} mode_e;
    typedef enum logic [2:0] {MENU_MIDI, MENU_POLARITY, MENU_XFADE, MENU_TILT,
                              MENU_PAN, MENU_POWERON} menu_e;
    typedef enum logic [1:0] {L1_MODE, L1_CHASE, L1_MSG} line1_e;
    typedef enum logic [2:0] {L2_BANK_SCENE, L2_OVERLAY, L2_MENU, L2_STEP,
                              L2_BLANK, L2_MSG} line2_e;
    typedef struct packed {
        logic       chase_run;
        logic [7:0] chase_id;
        logic [7:0] chase_step;
        logic [7:0] bank;
        logic [7:0] scene;
        logic       overlay;
        menu_e      menu;
    } panel_s;
    typedef struct packed {
        logic       en;
        logic [3:0] fixture;
        logic [3:0] fch;
        logic [7:0] value;
    } ch_wr_s;
    typedef struct packed {
        logic [8:0] num;
        logic [7:0] data;
        logic       last;
    } slot_s;
    typedef struct packed {
        line1_e     l1;
        line2_e     l2;
        mode_e      mode;
        logic [7:0] a;
        logic [7:0] b;
    } disp_s;
endpackage

// ==== bench/slot_sink.sv ====
// frame sink standing in for the fixtures on the output universe
`timescale 1ns/1ps

module slot_sink
    import opmode_pkg::*;
(
    input  wire logic  mclk,
    input  wire logic  arst_n,
    input  wire logic  stall,
    input  wire slot_s slot,
    input  wire logic  slot_valid,
    output logic       slot_ready
);
    logic [7:0] chan [1:256];
    logic [8:0] expect_num;
    int         frames;
    int         seq_err;
    wire        take      = slot_valid && slot_ready;
    wire        bad_order = slot.num !== expect_num || slot.last !== (expect_num == 9'h100);
    wire        bad_data  = slot.num > 9'h0a0 && slot.data !== 8'h00;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            slot_ready <= 1'b0;
            expect_num <= 9'h001;
            frames     <= 0;
            seq_err    <= 0;
        end else begin
            // every other cycle refused, so a pending slot must be held
            slot_ready <= stall ? ~slot_ready : 1'b1;
            if (take) begin
                chan[slot.num] <= slot.data;
                expect_num     <= (expect_num == 9'h100) ? 9'h001 : expect_num + 9'h001;
                frames         <= frames + int'(slot.last);
                seq_err        <= seq_err + int'(bad_order || bad_data);
            end
        end
    end
endmodule // slot_sink

// ==== bench/operation_mode_sequencer_tb.sv ====
// self-checking bench of the operation mode sequencer
`timescale 1ns/1ps

`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin errors++; \
    $display("[FAIL] %s expected %0h seen %0h", what, exp, got); end end

module operation_mode_sequencer_tb
    import opmode_pkg::*;
;
    localparam int HOLD = 20;
    localparam int MSG  = 16;
    logic       mclk = 1'b0;
    logic       arst_n, edit_key_pin, config_key_pin, msg_req, slot_valid, slot_ready, stall;
    logic [7:0] msg_code;
    panel_s     panel;
    ch_wr_s     ch_wr;
    mode_e      mode;
    disp_s      disp;
    slot_s      slot;
    int         errors = 0;
    int         total_checks = 0;

    always #5 mclk = ~mclk;

    operation_mode_sequencer #(.HOLD_CYCLES(HOLD), .MSG_CYCLES(MSG)) u_operation_mode_sequencer (
        .mclk(mclk), .arst_n(arst_n), .edit_key_pin(edit_key_pin),
        .config_key_pin(config_key_pin), .panel(panel), .ch_wr(ch_wr), .msg_req(msg_req),
        .msg_code(msg_code), .mode(mode), .disp(disp), .slot(slot), .slot_valid(slot_valid),
        .slot_ready(slot_ready));

    slot_sink u_slot_sink (.mclk(mclk), .arst_n(arst_n), .stall(stall), .slot(slot),
        .slot_valid(slot_valid), .slot_ready(slot_ready));

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic hold(input logic [1:0] k, input int n);
        {edit_key_pin, config_key_pin} <= k;
        tick(n);
        {edit_key_pin, config_key_pin} <= 2'b00;
        tick(8);
    endtask

    task automatic complete_run();
        if (errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic t_reset();
        `CHK("mode", PLAY, mode)
        `CHK("line1", L1_MODE, disp.l1)
    endtask

    task automatic t_modes();
        logic [1:0] ks [6] = '{2'b10, 2'b01, 2'b11, 2'b11, 2'b01, 2'b01};
        mode_e      ms [6] = '{EDIT, CONFIG, TEST, PLAY, CONFIG, PLAY};
        hold(2'b10, HOLD - 8);
        `CHK("short hold", PLAY, mode)
        {edit_key_pin, config_key_pin} <= 2'b10;
        tick(12);
        hold(2'b11, 12);
        `CHK("combo change", PLAY, mode)
        for (int i = 0; i < 6; i++) begin
            hold(ks[i], HOLD + 10);
            `CHK("mode", ms[i], mode)
            `CHK("shown mode", ms[i], disp.mode)
        end
    endtask

    task automatic t_display();
        panel.bank <= 8'h28;
        panel.scene <= 8'h09;
        tick(3);
        `CHK("bank", 8'h1d, disp.a)
        `CHK("scene", 8'h07, disp.b)
        panel.chase_run <= 1'b1;
        panel.chase_id <= 8'h07;
        panel.chase_step <= 8'hff;
        tick(3);
        `CHK("chase line", L1_CHASE, disp.l1)
        `CHK("step line", L2_STEP, disp.l2)
        `CHK("chase", 8'h05, disp.a)
        `CHK("step", 8'hf9, disp.b)
        panel.chase_run <= 1'b0;
        panel.bank <= 8'h02;
        panel.overlay <= 1'b1;
        hold(2'b10, HOLD + 10);
        `CHK("overlay", L2_OVERLAY, disp.l2)
        `CHK("edit bank", 8'h02, disp.a)
        hold(2'b01, HOLD + 10);
        for (int i = 0; i < 6; i++) begin
            panel.menu <= menu_e'(i);
            tick(3);
            `CHK("menu line", L2_MENU, disp.l2)
            `CHK("menu", 8'(i), disp.a)
            `CHK("menu b", 8'h00, disp.b)
        end
        hold(2'b11, HOLD + 10);
        `CHK("blank", L2_BLANK, disp.l2)
        `CHK("blank a", 8'h00, disp.a)
        msg_req <= 1'b1;
        msg_code <= 8'h5a;
        tick(1);
        msg_req <= 1'b0;
        tick(3);
        `CHK("message", L1_MSG, disp.l1)
        `CHK("code", 8'h5a, disp.a)
        `CHK("code b", 8'h00, disp.b)
        tick(MSG + 4);
        `CHK("revert", L1_MODE, disp.l1)
        `CHK("revert l2", L2_BLANK, disp.l2)
        hold(2'b11, HOLD + 10);
    endtask

    task automatic t_frames();
        int f;
        ch_wr <= '{en: 1'b1, fixture: 4'h0, fch: 4'h3, value: 8'hff};
        tick(1);
        ch_wr <= '{en: 1'b1, fixture: 4'h9, fch: 4'hf, value: 8'h01};
        tick(1);
        // index 160 and 255 lie beyond the live channels and must be dropped
        ch_wr <= '{en: 1'b1, fixture: 4'ha, fch: 4'h0, value: 8'h77};
        tick(1);
        ch_wr <= '{en: 1'b1, fixture: 4'hf, fch: 4'hf, value: 8'h77};
        tick(1);
        ch_wr.en <= 1'b0;
        tick(1200);
        `CHK("ch4", 8'hff, u_slot_sink.chan[4])
        `CHK("ch160", 8'h01, u_slot_sink.chan[160])
        `CHK("ch161", 8'h00, u_slot_sink.chan[161])
        `CHK("ch256", 8'h00, u_slot_sink.chan[256])
        `CHK("ch1", 8'h00, u_slot_sink.chan[1])
        hold(2'b10, HOLD + 10);
        tick(600);
        f = u_slot_sink.frames;
        tick(600);
        `CHK("edit frames", f, u_slot_sink.frames)
        // sink now takes a slot every cycle, so frames run back to back at full rate
        stall <= 1'b0;
        hold(2'b10, HOLD + 10);
        tick(600);
        `CHK("play frames", 1'b1, u_slot_sink.frames > f)
        `CHK("slot order", 0, u_slot_sink.seq_err)
    endtask

    initial begin
        arst_n = 1'b0;
        {edit_key_pin, config_key_pin} = 2'b00;
        panel = '0;
        ch_wr = '0;
        msg_req = 1'b0;
        msg_code = 8'h00;
        stall = 1'b1;
        tick(12);
        arst_n <= 1'b1;
        tick(4);
        t_reset();
        t_modes();
        t_display();
        t_frames();
        complete_run();
    end

    // whole sequence needs roughly 3600 cycles
    initial begin
        tick(20000);
        errors++;
        complete_run();
    end
endmodule // operation_mode_sequencer_tb
